/* File: tdcr_pkg.sv */
// package: constants, field layout and carrier types for the transmit dma configuration ram block
// Summary of operation
// - standard queue state, dword 1 bits 18-19, encodes next/next-pending pointer validity
// - priority queue state, dword 1 bits 20-21, same encoding for priority pointers
// - priority_in_progress at dword 1 bit 22 is one while a priority packet runs
// - dword 1 bits 23-31 and dword 4 bits 16-31 are unused storage
// - dword 2 high half holds start descriptor offset of packet in progress
// - dword 3 low is next pending offset, high is last pending offset
// - dword 5 low is last priority pending, high is next priority pending
// - 8-bit channel_select picks channel, 00h is channel 1, ffh channel 256
// - word_select bits 8-11 pick 16-bit word, 0000 to 1011
// - read control one fetches word; busy holds until data register loaded
// - read control zero writes data register into word; only word 0010 is stored, other words are left unchanged; busy until done
// - busy flag is read-only and reads one while an access runs
// - 16-bit data register carries indirect data both directions
package tdcr_pkg;
  localparam logic [11:0] TDCR_OFS_SELECT = 12'h870;
  localparam logic [11:0] TDCR_OFS_DATA   = 12'h874;
  localparam logic [15:0] TDCR_RST_SELECT = 16'h0000;
  localparam logic [15:0] TDCR_RST_DATA   = 16'h0000;
  localparam int          TDCR_SEL_CH_LSB = 0;
  localparam int          TDCR_SEL_WD_LSB = 8;
  localparam int          TDCR_SEL_RW_BIT = 14;
  localparam int          TDCR_SEL_BSY_BIT = 15;
  localparam logic [3:0]  TDCR_WORD_HOST  = 4'h2;
  localparam logic [3:0]  TDCR_WORD_LAST  = 4'hb;
  localparam int          TDCR_STQ_LSB    = 18;
  localparam int          TDCR_PRQ_LSB    = 20;
  localparam int          TDCR_PIP_BIT    = 22;
  localparam int          TDCR_NWORDS     = 12;
  localparam logic [2:0]  TDCR_DW_CFG     = 3'h1;
  localparam logic [2:0]  TDCR_DW_PTR     = 3'h2;
  localparam logic [2:0]  TDCR_DW_PEND    = 3'h3;
  localparam logic [2:0]  TDCR_DW_PRI     = 3'h4;
  localparam logic [2:0]  TDCR_DW_PPEND   = 3'h5;

  typedef enum logic [1:0] {
    TDCR_Q_NONE = 2'b00,
    TDCR_Q_NEXT = 2'b01,
    TDCR_Q_PEND = 2'b10,
    TDCR_Q_BOTH = 2'b11
  } tdcr_qstate_t;

  // register bus request
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [11:0] addr;
    logic [15:0] wdata;
  } tdcr_bus_req_t;

  // dma engine write port into the configuration ram
  typedef struct packed {
    logic        we;
    logic [7:0]  ch;
    logic [2:0]  dw;
    logic [31:0] data;
  } tdcr_dma_wr_t;
endpackage : tdcr_pkg

/* File: tdcr_ram.sv */
// storage of six dwords per channel, one dma write port, one host word port, one dma read port
module tdcr_ram #(
  parameter int NCH = 256
) (
  input  wire logic                 i_clk,      // register clock
  input  wire tdcr_pkg::tdcr_dma_wr_t i_dma_wr, // dma dword write
  input  wire logic [7:0]           i_dma_rch,  // dma read channel
  input  wire logic [2:0]           i_dma_rdw,  // dma read dword
  output logic [31:0]               o_dma_rdata,// dma read data
  input  wire logic                 i_h_we,     // host word write
  input  wire logic                 i_h_re,     // host word read
  input  wire logic [7:0]           i_h_ch,     // host channel
  input  wire logic [3:0]           i_h_word,   // host word index
  input  wire logic [15:0]          i_h_wdata,  // host word data
  output logic [15:0]               o_h_rdata   // host word read data
);
  logic [15:0] mem_lo [NCH*6];
  logic [15:0] mem_hi [NCH*6];
  logic [10:0] h_idx;
  logic [10:0] d_idx;
  logic [10:0] r_idx;

  assign h_idx = 11'(i_h_ch) * 11'd6 + 11'(i_h_word[3:1]);
  assign d_idx = 11'(i_dma_wr.ch) * 11'd6 + 11'(i_dma_wr.dw);
  assign r_idx = 11'(i_dma_rch) * 11'd6 + 11'(i_dma_rdw);

  // dma write has priority over the host word on the same cycle; host writes the low or high half picked by i_h_word bit 0
  always_ff @(posedge i_clk) begin
    if (i_dma_wr.we) begin
      mem_lo[d_idx] <= i_dma_wr.data[15:0];
    end else if (i_h_we && !i_h_word[0]) begin
      mem_lo[h_idx] <= i_h_wdata;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_dma_wr.we) begin
      mem_hi[d_idx] <= i_dma_wr.data[31:16];
    end else if (i_h_we && i_h_word[0]) begin
      mem_hi[h_idx] <= i_h_wdata;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_h_re) begin
      o_h_rdata <= i_h_word[0] ? mem_hi[h_idx] : mem_lo[h_idx];
    end
  end

  always_ff @(posedge i_clk) begin
    o_dma_rdata <= {mem_hi[r_idx], mem_lo[r_idx]};
  end
endmodule : tdcr_ram

/* File: tdcr_top.sv */
// indirect access port and dma field packing of the transmit dma configuration ram
module tdcr_top #(
  parameter int NCH = 256
) (
  input  wire logic                   i_clk,          // 125 mhz register clock
  input  wire logic                   i_rst_n,        // async reset, active low
  input  wire tdcr_pkg::tdcr_bus_req_t i_bus,         // register access, one-cycle strobes
  output logic [15:0]                 o_bus_rdata,    // read data, valid cycle after rd
  input  wire tdcr_pkg::tdcr_dma_wr_t i_dma_wr,       // raw dword write from the dma engine
  input  wire logic [7:0]             i_dma_ch,       // channel for field update and readback
  input  wire logic                   i_stq_we,       // update standard queue state
  input  wire tdcr_pkg::tdcr_qstate_t i_stq,          // new standard queue state
  input  wire logic                   i_prq_we,       // update priority queue state
  input  wire tdcr_pkg::tdcr_qstate_t i_prq,          // new priority queue state
  input  wire logic                   i_pip_set,      // priority packet started
  input  wire logic                   i_pip_clr,      // priority packet finished
  input  wire logic [2:0]             i_dma_rdw,      // dma read dword
  output logic [31:0]                 o_dma_rdata,    // dma read data
  output tdcr_pkg::tdcr_qstate_t      o_stq,          // standard queue state of i_dma_ch
  output tdcr_pkg::tdcr_qstate_t      o_prq,          // priority queue state of i_dma_ch
  output logic                        o_pip,          // priority in progress of i_dma_ch
  output logic                        o_indirect_busy // busy flag
);
  typedef enum logic [1:0] {
    TDCR_S_IDLE = 2'b00,
    TDCR_S_RD   = 2'b01,
    TDCR_S_RDW  = 2'b10,
    TDCR_S_WR   = 2'b11
  } tdcr_state_t;

  tdcr_state_t  state_reg;
  logic [7:0]   channel_select_reg;
  logic [3:0]   word_select_reg;
  logic         indirect_read_write_reg;
  logic [15:0]  indirect_data_reg;
  logic [15:0]  ram_rdata;
  logic         sel_wr;
  logic         dat_wr;
  logic [15:0]  select_view;

  // per-channel queue state and priority flag are kept in flops so the dma can update them as fields
  tdcr_pkg::tdcr_qstate_t stq_reg [NCH];
  tdcr_pkg::tdcr_qstate_t prq_reg [NCH];
  logic [NCH-1:0]         pip_reg;

  assign sel_wr = i_bus.wr && (i_bus.addr == tdcr_pkg::TDCR_OFS_SELECT);
  assign dat_wr = i_bus.wr && (i_bus.addr == tdcr_pkg::TDCR_OFS_DATA);
  assign o_indirect_busy = (state_reg != TDCR_S_IDLE);
  assign select_view = {o_indirect_busy, indirect_read_write_reg, 2'b00,
                        word_select_reg, channel_select_reg};

  // host access request: a select write while idle with word_select up to 1011 starts a read or a write
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_reg <= TDCR_S_IDLE;
    end else begin
      case (state_reg)
        TDCR_S_IDLE: begin
          if (sel_wr && i_bus.wdata[tdcr_pkg::TDCR_SEL_WD_LSB +: 4] <= tdcr_pkg::TDCR_WORD_LAST) begin
            state_reg <= i_bus.wdata[tdcr_pkg::TDCR_SEL_RW_BIT] ? TDCR_S_RD : TDCR_S_WR;
          end
        end
        TDCR_S_RD:  state_reg <= TDCR_S_RDW;
        TDCR_S_RDW: state_reg <= TDCR_S_IDLE;
        TDCR_S_WR:  state_reg <= TDCR_S_IDLE;
        default:    state_reg <= TDCR_S_IDLE;
      endcase
    end
  end

  // select fields are frozen while busy so the access in flight keeps its target
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      channel_select_reg      <= tdcr_pkg::TDCR_RST_SELECT[7:0];
      word_select_reg         <= tdcr_pkg::TDCR_RST_SELECT[11:8];
      indirect_read_write_reg <= tdcr_pkg::TDCR_RST_SELECT[14];
    end else if (sel_wr && !o_indirect_busy) begin
      channel_select_reg      <= i_bus.wdata[tdcr_pkg::TDCR_SEL_CH_LSB +: 8];
      word_select_reg         <= i_bus.wdata[tdcr_pkg::TDCR_SEL_WD_LSB +: 4];
      indirect_read_write_reg <= i_bus.wdata[tdcr_pkg::TDCR_SEL_RW_BIT];
    end
  end

  // data register: host load, or fetched word at the end of a read
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      indirect_data_reg <= tdcr_pkg::TDCR_RST_DATA;
    end else if (state_reg == TDCR_S_RDW) begin
      indirect_data_reg <= ram_rdata;
    end else if (dat_wr && !o_indirect_busy) begin
      indirect_data_reg <= i_bus.wdata;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_bus_rdata <= 16'h0000;
    end else if (i_bus.rd) begin
      o_bus_rdata <= (i_bus.addr == tdcr_pkg::TDCR_OFS_SELECT) ? select_view :
                     (i_bus.addr == tdcr_pkg::TDCR_OFS_DATA)   ? indirect_data_reg : 16'h0000;
    end
  end

  // queue state and priority flags per channel
  generate
    for (genvar c = 0; c < NCH; c++) begin : g_ch
      always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
          stq_reg[c] <= tdcr_pkg::TDCR_Q_NONE;
          prq_reg[c] <= tdcr_pkg::TDCR_Q_NONE;
          pip_reg[c] <= 1'b0;
        end else if (i_dma_ch == 8'(c)) begin
          if (i_stq_we) stq_reg[c] <= i_stq;
          if (i_prq_we) prq_reg[c] <= i_prq;
          if (i_pip_set) pip_reg[c] <= 1'b1;
          else if (i_pip_clr) pip_reg[c] <= 1'b0;
        end
      end
    end
  endgenerate

  assign o_stq = stq_reg[i_dma_ch];
  assign o_prq = prq_reg[i_dma_ch];
  assign o_pip = pip_reg[i_dma_ch];

  // word storage; host writes are accepted only to the host word of dword 1
  logic        h_we;
  logic [15:0] h_rdata_q;
  logic [31:0] dma_raw;
  logic [15:0] st_word;
  logic        st_word_d;
  assign h_we = (state_reg == TDCR_S_WR) && (word_select_reg == tdcr_pkg::TDCR_WORD_HOST);

  tdcr_ram #(.NCH(NCH)) u_ram (
    .i_clk      (i_clk),
    .i_dma_wr   (i_dma_wr),
    .i_dma_rch  (i_dma_ch),
    .i_dma_rdw  (i_dma_rdw),
    .o_dma_rdata(dma_raw),
    .i_h_we     (h_we),
    .i_h_re     (state_reg == TDCR_S_RD),
    .i_h_ch     (channel_select_reg),
    .i_h_word   (word_select_reg),
    .i_h_wdata  (indirect_data_reg),
    .o_h_rdata  (h_rdata_q)
  );

  // upper word of dword 1 shows the live state fields; bits 23-31 read as zero
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_word_d <= 1'b0;
      st_word   <= 16'h0000;
    end else begin
      st_word_d <= (state_reg == TDCR_S_RD) && (word_select_reg == 4'h3);
      st_word   <= {h_rdata_q[15:7], pip_reg[channel_select_reg], prq_reg[channel_select_reg],
                    stq_reg[channel_select_reg], h_rdata_q[1:0]};
    end
  end
  // st_word is built from the live flops in the RD cycle against stale ram data; ram bits 16-17 come next
  assign ram_rdata = st_word_d ? {9'h000, st_word[6:2], h_rdata_q[1:0]} : h_rdata_q;
  assign o_dma_rdata = (i_dma_rdw == tdcr_pkg::TDCR_DW_CFG) ?
                       {9'h000, o_pip, o_prq, o_stq, dma_raw[17:0]} : dma_raw;

  // a read is busy for the fetch and the load cycle, a write for its single store cycle
  sequence s_read_busy;
    o_indirect_busy [*2] ##1 !o_indirect_busy;
  endsequence

  sequence s_write_busy;
    o_indirect_busy ##1 !o_indirect_busy;
  endsequence

  property p_read_busy;
    @(posedge i_clk) disable iff (!i_rst_n)
      (state_reg == TDCR_S_IDLE && sel_wr && i_bus.wdata[14] && i_bus.wdata[11:8] <= 4'hb)
      |=> s_read_busy;
  endproperty
  a_read_busy: assert property (p_read_busy) else $error("read busy length wrong");

  property p_write_busy;
    @(posedge i_clk) disable iff (!i_rst_n)
      (state_reg == TDCR_S_IDLE && sel_wr && !i_bus.wdata[14] && i_bus.wdata[11:8] <= 4'hb)
      |=> s_write_busy;
  endproperty
  a_write_busy: assert property (p_write_busy) else $error("write busy length wrong");

  property p_ro_write;
    @(posedge i_clk) disable iff (!i_rst_n)
      (state_reg == TDCR_S_WR && word_select_reg != 4'h2) |-> !h_we;
  endproperty
  a_ro_write: assert property (p_ro_write) else $error("write to dma-only word");

  property p_data_hold;
    @(posedge i_clk) disable iff (!i_rst_n)
      (state_reg == TDCR_S_WR) |=> $stable(indirect_data_reg);
  endproperty
  a_data_hold: assert property (p_data_hold) else $error("data changed by write");

  property p_pip;
    @(posedge i_clk) disable iff (!i_rst_n)
      i_pip_set |=> pip_reg[$past(i_dma_ch)];
  endproperty
  a_pip: assert property (p_pip) else $error("priority flag not set");

  property p_pip_clr;
    @(posedge i_clk) disable iff (!i_rst_n)
      (i_pip_clr && !i_pip_set) |=> !pip_reg[$past(i_dma_ch)];
  endproperty
  a_pip_clr: assert property (p_pip_clr) else $error("priority flag not cleared");

  property p_stq_upd;
    @(posedge i_clk) disable iff (!i_rst_n)
      i_stq_we |=> (stq_reg[$past(i_dma_ch)] == $past(i_stq));
  endproperty
  a_stq_upd: assert property (p_stq_upd) else $error("standard queue state not stored");

  property p_prq_upd;
    @(posedge i_clk) disable iff (!i_rst_n)
      i_prq_we |=> (prq_reg[$past(i_dma_ch)] == $past(i_prq));
  endproperty
  a_prq_upd: assert property (p_prq_upd) else $error("priority queue state not stored");

  // busy only ever starts from a host select write
  property p_busy_start;
    @(posedge i_clk) disable iff (!i_rst_n)
      $rose(o_indirect_busy) |-> $past(sel_wr);
  endproperty
  a_busy_start: assert property (p_busy_start) else $error("busy rose without select write");

  property p_sel_hold;
    @(posedge i_clk) disable iff (!i_rst_n)
      o_indirect_busy |=> ($stable(channel_select_reg) && $stable(word_select_reg));
  endproperty
  a_sel_hold: assert property (p_sel_hold) else $error("select moved during access");

  // host data loads are refused while an access runs, except the read's own load
  property p_data_refused;
    @(posedge i_clk) disable iff (!i_rst_n)
      (o_indirect_busy && state_reg != TDCR_S_RDW) |=> $stable(indirect_data_reg);
  endproperty
  a_data_refused: assert property (p_data_refused) else $error("data loaded while busy");
endmodule : tdcr_top

/* File: tdcr_host_model.sv */
// host processor model: strobes the indirect select and data registers
module tdcr_host_model (
  input  wire logic               i_clk,   // register clock
  input  wire logic [15:0]        i_rdata, // register read data
  input  wire logic               i_busy,  // indirect busy flag
  output tdcr_pkg::tdcr_bus_req_t o_bus    // register access strobes
);
  timeunit 1ns;
  timeprecision 1ps;
  initial o_bus = '0;

  // one-cycle strobe; released address and data lines turn to their inverse
  task automatic put(input logic w, input logic [11:0] a, input logic [15:0] d);
    @(negedge i_clk);
    o_bus = '{wr: w, rd: ~w, addr: a, wdata: d};
    @(negedge i_clk);
    o_bus = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask : put

  task automatic wr_reg(input logic [11:0] a, input logic [15:0] d);
    put(1'b1, a, d);
  endtask : wr_reg

  task automatic rd_reg(input logic [11:0] a, output logic [15:0] d);
    put(1'b0, a, 16'h0000);
    @(posedge i_clk);
    #1 d = i_rdata;
  endtask : rd_reg

  // counts falling edges until busy clears, bounded
  task automatic wait_idle(output int n);
    n = 0;
    while (i_busy !== 1'b0 && n < 20) begin
      @(negedge i_clk);
      n++;
    end
  endtask : wait_idle
endmodule : tdcr_host_model

/* File: tb_top.sv */
// self-checking bench for the transmit dma configuration ram indirect port
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic                    i_clk, i_rst_n, stq_we, prq_we, pip_set, pip_clr, busy, pip;
  tdcr_pkg::tdcr_bus_req_t bus;
  tdcr_pkg::tdcr_dma_wr_t  dma_wr;
  tdcr_pkg::tdcr_qstate_t  stq, prq, stq_o, prq_o;
  logic [15:0]             rdata, d;
  logic [7:0]              dma_ch;
  logic [2:0]              rdw;
  logic [31:0]             dma_rdata;
  int                      n_mismatch = 0;
  int                      checked = 0;

  initial begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end

  tdcr_top dut_u (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_bus(bus), .o_bus_rdata(rdata), .i_dma_wr(dma_wr),
    .i_dma_ch(dma_ch), .i_stq_we(stq_we), .i_stq(stq), .i_prq_we(prq_we), .i_prq(prq), .i_pip_set(pip_set),
    .i_pip_clr(pip_clr), .i_dma_rdw(rdw), .o_dma_rdata(dma_rdata), .o_stq(stq_o), .o_prq(prq_o), .o_pip(pip),
    .o_indirect_busy(busy));
  tdcr_host_model hm (.i_clk(i_clk), .i_rdata(rdata), .i_busy(busy), .o_bus(bus));

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic results;
    $display("mismatches %0d checks %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : results

  function automatic logic [31:0] pat(input logic [7:0] ch, input logic [2:0] dw);
    return {ch, 5'h11, dw, ~ch, 5'h0a, dw};
  endfunction : pat

  task automatic access(input logic [7:0] ch, input logic [3:0] wd, input logic rw, output logic [15:0] q);
    int n;
    hm.wr_reg(tdcr_pkg::TDCR_OFS_SELECT, {1'b0, rw, 2'b00, wd, ch});
    hm.wait_idle(n);
    chk("busy_cycles", rw ? 2 : 1, n);
    q = 16'h0000;
    if (rw) hm.rd_reg(tdcr_pkg::TDCR_OFS_DATA, q);
  endtask : access

  task automatic dma_put(input logic [7:0] ch, input logic [2:0] dw, input logic [31:0] v);
    @(negedge i_clk);
    dma_wr = '{we: 1'b1, ch: ch, dw: dw, data: v};
    @(negedge i_clk);
    dma_wr.we = 1'b0;
  endtask : dma_put

  task automatic fld(input logic [1:0] q, input logic s, input logic c);
    @(negedge i_clk);
    {stq_we, prq_we, pip_set, pip_clr} = {2'b11, s, c};
    stq = tdcr_pkg::tdcr_qstate_t'(q);
    prq = tdcr_pkg::tdcr_qstate_t'(~q);
    @(negedge i_clk);
    {stq_we, prq_we, pip_set, pip_clr} = 4'h0;
    repeat (2) @(posedge i_clk);
    #1;
  endtask : fld

  task automatic t_reset;
    hm.rd_reg(tdcr_pkg::TDCR_OFS_SELECT, d);
    chk("select_reset", tdcr_pkg::TDCR_RST_SELECT, d);
    hm.rd_reg(tdcr_pkg::TDCR_OFS_DATA, d);
    chk("data_reset", tdcr_pkg::TDCR_RST_DATA, d);
    chk("fields_reset", 5'h00, {pip, prq_o, stq_o});
  endtask : t_reset

  task automatic t_ptrs;
    logic [31:0] v;
    for (int c = 0; c < 2; c++)
      for (int w = 2; w < 6; w++) dma_put(c ? 8'hff : 8'h00, w[2:0], pat(c ? 8'hff : 8'h00, w[2:0]));
    dma_ch = 8'hff;
    rdw = 3'h3;
    repeat (2) @(posedge i_clk);
    #1;
    chk("dma_rdata", pat(8'hff, 3'h3), dma_rdata);
    for (int c = 0; c < 2; c++)
      for (int w = 4; w < 12; w++) begin
        v = pat(c ? 8'hff : 8'h00, w[3:1]);
        access(c ? 8'hff : 8'h00, w[3:0], 1'b1, d);
        if (w != 9) chk("ram_word", w[0] ? v[31:16] : v[15:0], d);
      end
  endtask : t_ptrs

  task automatic t_host;
    hm.wr_reg(tdcr_pkg::TDCR_OFS_DATA, 16'h0003);
    access(8'h07, tdcr_pkg::TDCR_WORD_HOST, 1'b0, d);
    hm.wr_reg(tdcr_pkg::TDCR_OFS_SELECT, {1'b0, 1'b1, 2'b00, tdcr_pkg::TDCR_WORD_HOST, 8'h07});
    hm.wr_reg(tdcr_pkg::TDCR_OFS_DATA, 16'h0001);
    hm.rd_reg(tdcr_pkg::TDCR_OFS_DATA, d);
    chk("data_locked_busy", 16'h0003, d);
    access(8'h07, tdcr_pkg::TDCR_WORD_HOST, 1'b1, d);
    chk("host_word", 16'h0003, d);
    dma_put(8'h07, 3'h4, 32'h0000_1234);
    hm.wr_reg(tdcr_pkg::TDCR_OFS_DATA, 16'hbeef);
    access(8'h07, 4'h8, 1'b0, d);
    access(8'h07, 4'h8, 1'b1, d);
    chk("dma_word_kept", 16'h1234, d);
    hm.wr_reg(tdcr_pkg::TDCR_OFS_SELECT, 16'h4c07);
    chk("busy_bad_word", 1'b0, busy);
  endtask : t_host

  task automatic t_fields;
    dma_ch = 8'h05;
    rdw = tdcr_pkg::TDCR_DW_CFG;
    for (int q = 0; q < 4; q++) begin
      fld(q[1:0], 1'b0, 1'b0);
      chk("queue_states", {~q[1:0], q[1:0]}, {prq_o, stq_o});
      chk("cfg_fields", {9'h000, 1'b0, ~q[1:0], q[1:0]}, dma_rdata[31:18]);
    end
    fld(2'b01, 1'b1, 1'b1);
    chk("pip_set", 2'b11, {pip, dma_rdata[22]});
    access(8'h05, 4'h3, 1'b1, d);
    chk("cfg_upper", 5'h19, d[6:2]);
    fld(2'b01, 1'b0, 1'b1);
    chk("pip_clr", 2'b00, {pip, dma_rdata[22]});
  endtask : t_fields

  initial begin
    #(5000 * 8);
    n_mismatch++;
    results();
  end

  initial begin
    {i_rst_n, stq_we, prq_we, pip_set, pip_clr} = 5'h00;
    dma_wr = '0;
    dma_ch = 8'h00;
    rdw = 3'h0;
    stq = tdcr_pkg::TDCR_Q_NONE;
    prq = tdcr_pkg::TDCR_Q_NONE;
    repeat (4) @(posedge i_clk);
    @(negedge i_clk);
    i_rst_n = 1'b1;
    t_reset();
    t_ptrs();
    t_host();
    t_fields();
    results();
  end
endmodule : tb_top
